// ### hdl/mattr_pkg.sv
// attribute-select constants: control codes, field positions, masks and encodings
// assumes a single processor clock domain and 32-bit control register moves
package mattr_pkg;
    // control register move codes
    localparam logic [11:0] CODE_CACHE_CTRL = 12'h002;
    localparam logic [11:0] CODE_REGION_ZERO = 12'h004;
    localparam logic [11:0] CODE_REGION_ONE = 12'h005;
    // reset values
    localparam logic [31:0] CACHE_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] REGION_RST = 32'h0000_0000;
    // implemented bits; everything else is reserved, ignored on write, zero on read
    localparam logic [31:0] CACHE_CTRL_WMASK = 32'h9800_0723;
    localparam logic [31:0] REGION_WMASK = 32'hffff_e064;
    // cache control field positions
    localparam int ICACHE_ON_BIT = 31;
    localparam int BURST_ALLOW_BIT = 10;
    localparam int DEF_POLICY_BIT = 9;
    localparam int DEF_POSTED_BIT = 8;
    localparam int DEF_GUARD_BIT = 5;
    localparam int FILL_SEL_HI = 1;
    localparam int FILL_SEL_LO = 0;
    // region field positions
    localparam int BASE_HI = 31;
    localparam int BASE_LO = 24;
    localparam int MASK_HI = 23;
    localparam int MASK_LO = 16;
    localparam int ACTIVE_BIT = 15;
    localparam int PRIV_HI = 14;
    localparam int PRIV_LO = 13;
    localparam int REG_POLICY_BIT = 6;
    localparam int REG_POSTED_BIT = 5;
    localparam int REG_GUARD_BIT = 2;
    // privilege match encodings (1x matches any)
    localparam logic [1:0] PRIV_USER_ONLY = 2'b00;
    localparam logic [1:0] PRIV_SUPER_ONLY = 2'b01;
    // line fill size selector encodings and longword offsets
    localparam logic [1:0] FILL_SEL_LAST = 2'b00;
    localparam logic [1:0] FILL_SEL_UPPER = 2'b01;
    localparam logic [1:0] LW_OFS_TWO = 2'b10;
    localparam logic [1:0] LW_OFS_THREE = 2'b11;
    localparam int LW_OFS_HI = 3;
    localparam int LW_OFS_LO = 2;
    // sram region: 8 KB (2K x 32), base on an 8K boundary
    localparam int SRAM_BASE_LO = 13;
    localparam int SRAM_WORDS = 2048;
    // local write handshake states
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_WAIT = 2'b10
    } wr_state_t;
endpackage

// ### hdl/region_match.sv
// one address-region attribute register compare: base, mask, privilege, active
// assumes the reference address and privilege are stable while being evaluated
`timescale 1ns/1ps
module region_match (
    // region register contents
    input wire logic [31:0] region_i,
    // reference
    input wire logic [7:0] addr_hi_i,
    input wire logic supervisor_i,
    // result
    output logic hit_o
);
    import mattr_pkg::*;

    logic [7:0] base_bits;
    logic [7:0] mask_bits;
    logic [1:0] priv_sel;
    logic addr_ok;
    logic priv_ok;

    assign base_bits = region_i[BASE_HI:BASE_LO];
    assign mask_bits = region_i[MASK_HI:MASK_LO];
    assign priv_sel = region_i[PRIV_HI:PRIV_LO];

    assign addr_ok = ((base_bits ^ addr_hi_i) & ~mask_bits) == 8'h00;

    always_comb begin
        if (priv_sel == PRIV_USER_ONLY) begin
            priv_ok = !supervisor_i;
        end else if (priv_sel == PRIV_SUPER_ONLY) begin
            priv_ok = supervisor_i;
        end else begin
            priv_ok = 1'b1;
        end
    end

    assign hit_o = region_i[ACTIVE_BIT] && addr_ok && priv_ok;
endmodule

// ### hdl/fill_size.sv
// external fetch size choice from the miss longword offset and the size selector
// assumes the offset is address bits 3:2 of the missing fetch
`timescale 1ns/1ps
module fill_size (
    // selector and offset
    input wire logic [1:0] sel_i,
    input wire logic [1:0] lw_ofs_i,
    // result: high asks for a whole line, low for one longword
    output logic line_o
);
    import mattr_pkg::*;

    // size table; top two settings always fetch a line
    always_comb begin
        if (sel_i == FILL_SEL_LAST) begin
            line_o = (lw_ofs_i != LW_OFS_THREE);
        end else if (sel_i == FILL_SEL_UPPER) begin
            line_o = (lw_ofs_i != LW_OFS_THREE) && (lw_ofs_i != LW_OFS_TWO);
        end else begin
            line_o = 1'b1;
        end
    end
endmodule

// ### hdl/memory_attribute_select.sv
// memory attribute select: resolves cacheability, posting and write guard per reference
// assumes the core holds a reference until REF_READY_O and moves control registers itself
//
// Overview of operation
// - burst allow fills buffer for uncached fetches
// - uncached fill data never enters cache
// - default policy: 0 cacheable, 1 noncacheable
// - default unposted write waits for external completion
// - default posted write terminates at once
// - size selector picks line or longword fetch
// - matching region supplies attributes, else defaults
// - regions ignored for sram-mapped references
// - regions write-only, readable in debug halt
// - reset clears both regions completely
// - base compared with address bits 31:24
// - set mask bits ignore address bits
// - privilege field: user, supervisor, or any
// - region policy: 0 cacheable, 1 noncacheable
// - region posted bit ends writes at once
// - guarded writes outside sram end in access error
// - sram is 8 KB at 8K-aligned base
// - sram fetch data wins over cache
// - sram references never allocate into cache
// - no burst: uncached fetch longword, bypass buffer
`timescale 1ns/1ps
module memory_attribute_select (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    // control register moves from the core
    input wire logic CREG_WR_I,
    input wire logic CREG_RD_I,
    input wire logic [11:0] CREG_CODE_I,
    input wire logic [31:0] CREG_WDATA_I,
    input wire logic DBG_HALT_I,
    output logic [31:0] CREG_RDATA_O,
    // sram placement, owned by the sram base register elsewhere
    input wire logic [31:mattr_pkg::SRAM_BASE_LO] SRAM_BASE_I,
    input wire logic SRAM_VALID_I,
    // reference from the core
    input wire logic REF_VALID_I,
    input wire logic [31:0] REF_ADDR_I,
    input wire logic REF_WRITE_I,
    input wire logic REF_IFETCH_I,
    input wire logic REF_SUPER_I,
    output logic REF_READY_O,
    // resolved attributes to cache and bus controller
    output logic ATTR_VALID_O,
    output logic CACHEABLE_O,
    output logic POSTED_O,
    output logic SRAM_SEL_O,
    output logic FILL_LINE_O,
    output logic FILL_BUF_O,
    output logic ALLOC_O,
    // local write termination
    input wire logic EXT_WR_DONE_I,
    output logic LB_WR_TERM_O,
    output logic LB_WR_ERR_O
);
    import mattr_pkg::*;

    logic [31:0] cache_ctrl_ff;
    logic [31:0] region0_ff;
    logic [31:0] region1_ff;
    wr_state_t state_ff;
    wr_state_t nxt_state;
    logic accept;
    logic sram_hit;
    logic hit0_raw;
    logic hit1_raw;
    logic hit0;
    logic hit1;
    logic eff_cacheable;
    logic eff_posted;
    logic eff_guard;
    logic size_line;
    logic icache_on;
    logic burst_allow;
    logic nxt_fill_line;
    logic nxt_fill_buf;
    logic nxt_alloc;
    logic wr_now;
    logic wr_err;

    assign accept = REF_VALID_I && REF_READY_O;
    assign icache_on = cache_ctrl_ff[ICACHE_ON_BIT];
    assign burst_allow = cache_ctrl_ff[BURST_ALLOW_BIT];

    // register writes; reserved bits are dropped so they read back as zero
    // reset clears regions
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            cache_ctrl_ff <= CACHE_CTRL_RST;
            region0_ff <= REGION_RST;
            region1_ff <= REGION_RST;
        end else if (CREG_WR_I) begin
            if (CREG_CODE_I == CODE_CACHE_CTRL) begin
                cache_ctrl_ff <= CREG_WDATA_I & CACHE_CTRL_WMASK;
            end else if (CREG_CODE_I == CODE_REGION_ZERO) begin
                region0_ff <= CREG_WDATA_I & REGION_WMASK;
            end else if (CREG_CODE_I == CODE_REGION_ONE) begin
                region1_ff <= CREG_WDATA_I & REGION_WMASK;
            end
        end
    end

    // reads only return contents in debug halt; normal reads see zero
    // debug-only readback
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            CREG_RDATA_O <= 32'h0000_0000;
        end else if (CREG_RD_I && DBG_HALT_I) begin
            if (CREG_CODE_I == CODE_CACHE_CTRL) begin
                CREG_RDATA_O <= cache_ctrl_ff;
            end else if (CREG_CODE_I == CODE_REGION_ZERO) begin
                CREG_RDATA_O <= region0_ff;
            end else if (CREG_CODE_I == CODE_REGION_ONE) begin
                CREG_RDATA_O <= region1_ff;
            end else begin
                CREG_RDATA_O <= 32'h0000_0000;
            end
        end else begin
            CREG_RDATA_O <= 32'h0000_0000;
        end
    end

    assign sram_hit = SRAM_VALID_I && (REF_ADDR_I[31:SRAM_BASE_LO] == SRAM_BASE_I);

    region_match u_region0 (
        .region_i(region0_ff),
        .addr_hi_i(REF_ADDR_I[BASE_HI:BASE_LO]),
        .supervisor_i(REF_SUPER_I),
        .hit_o(hit0_raw)
    );

    region_match u_region1 (
        .region_i(region1_ff),
        .addr_hi_i(REF_ADDR_I[BASE_HI:BASE_LO]),
        .supervisor_i(REF_SUPER_I),
        .hit_o(hit1_raw)
    );

    assign hit0 = hit0_raw && !sram_hit;
    assign hit1 = hit1_raw && !sram_hit;

    // attribute source: region zero, then region one, then the defaults
    // region priority
    always_comb begin
        if (hit0) begin
            eff_cacheable = !region0_ff[REG_POLICY_BIT];
            eff_posted = region0_ff[REG_POSTED_BIT];
            eff_guard = region0_ff[REG_GUARD_BIT];
        end else if (hit1) begin
            eff_cacheable = !region1_ff[REG_POLICY_BIT];
            eff_posted = region1_ff[REG_POSTED_BIT];
            eff_guard = region1_ff[REG_GUARD_BIT];
        end else begin
            eff_cacheable = !cache_ctrl_ff[DEF_POLICY_BIT];
            eff_posted = cache_ctrl_ff[DEF_POSTED_BIT];
            eff_guard = cache_ctrl_ff[DEF_GUARD_BIT];
        end
    end

    fill_size u_fill_size (
        .sel_i(cache_ctrl_ff[FILL_SEL_HI:FILL_SEL_LO]),
        .lw_ofs_i(REF_ADDR_I[LW_OFS_HI:LW_OFS_LO]),
        .line_o(size_line)
    );

    // fetch shaping; sram fetches are served locally and never go to fill or cache
    always_comb begin
        nxt_fill_line = 1'b0;
        nxt_fill_buf = 1'b0;
        nxt_alloc = 1'b0;
        if (REF_IFETCH_I && !REF_WRITE_I && !sram_hit && icache_on) begin
            if (eff_cacheable) begin
                nxt_fill_line = size_line;
                nxt_fill_buf = 1'b1;
                nxt_alloc = 1'b1;
            end else if (burst_allow) begin
                nxt_fill_line = size_line;
                nxt_fill_buf = 1'b1;
            end
        end
    end

    // attribute outputs, one cycle after the reference is taken
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            ATTR_VALID_O <= 1'b0;
            CACHEABLE_O <= 1'b0;
            POSTED_O <= 1'b0;
            SRAM_SEL_O <= 1'b0;
            FILL_LINE_O <= 1'b0;
            FILL_BUF_O <= 1'b0;
            ALLOC_O <= 1'b0;
        end else begin
            ATTR_VALID_O <= accept;
            // sram data is not cached, so cacheable reads low for it
            CACHEABLE_O <= accept && eff_cacheable && !sram_hit;
            POSTED_O <= accept && eff_posted && !sram_hit;
            SRAM_SEL_O <= accept && sram_hit;
            FILL_LINE_O <= accept && nxt_fill_line;
            FILL_BUF_O <= accept && nxt_fill_buf;
            ALLOC_O <= accept && nxt_alloc;
        end
    end

    // writes that end without waiting: guarded, posted, or sram-served
    // guard turns writes into errors, except for sram-served writes
    assign wr_err = REF_WRITE_I && !sram_hit && eff_guard;
    assign wr_now = REF_WRITE_I && (sram_hit || eff_guard || eff_posted);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            WR_IDLE: begin
                if (accept && REF_WRITE_I && !wr_now) begin
                    nxt_state = WR_WAIT;
                end
            end
            WR_WAIT: begin
                if (EXT_WR_DONE_I) begin
                    nxt_state = WR_IDLE;
                end
            end
            default: begin
                nxt_state = WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            state_ff <= WR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ready drops while an unposted write waits; refs are not reordered past it
    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            REF_READY_O <= 1'b0;
        end else begin
            REF_READY_O <= (nxt_state == WR_IDLE);
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (!RSTN_I) begin
            LB_WR_TERM_O <= 1'b0;
            LB_WR_ERR_O <= 1'b0;
        end else begin
            LB_WR_TERM_O <= (accept && wr_now) || ((state_ff == WR_WAIT) && EXT_WR_DONE_I);
            LB_WR_ERR_O <= accept && wr_err;
        end
    end

    chk_reset_clear: assert property (@(posedge CLK_SYS_I)
        !RSTN_I |=> (region0_ff == REGION_RST) && (region1_ff == REGION_RST))
        else $error("region registers not cleared by reset");

    chk_read_gated: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        CREG_RD_I && !DBG_HALT_I |=> CREG_RDATA_O == 32'h0000_0000)
        else $error("register read outside debug halt returned data");

    chk_no_alloc_nc: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        accept && REF_IFETCH_I && !eff_cacheable |=> !ALLOC_O)
        else $error("noncacheable fetch allocated into cache");

    chk_sram_alloc: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        accept && sram_hit |=> SRAM_SEL_O && !ALLOC_O && !FILL_BUF_O)
        else $error("sram reference reached cache fill");

    chk_guard_err: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        accept && REF_WRITE_I && !sram_hit && eff_guard |=> LB_WR_TERM_O && LB_WR_ERR_O)
        else $error("guarded write not ended with error");

    chk_posted_now: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        accept && REF_WRITE_I && !sram_hit && !eff_guard && eff_posted
        |=> LB_WR_TERM_O && !LB_WR_ERR_O && REF_READY_O)
        else $error("posted write not terminated at once");

    chk_hold_term: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        accept && REF_WRITE_I && !wr_now ##1 !EXT_WR_DONE_I |=> !LB_WR_TERM_O && !REF_READY_O)
        else $error("unposted write terminated before external completion");

    chk_burst_off: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        accept && REF_IFETCH_I && !sram_hit && !eff_cacheable && !burst_allow
        |=> !FILL_LINE_O && !FILL_BUF_O)
        else $error("uncached fetch used fill buffer without burst allow");

    chk_default_pol: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        accept && !sram_hit && !hit0 && !hit1
        |=> CACHEABLE_O == !$past(cache_ctrl_ff[DEF_POLICY_BIT]))
        else $error("default policy not applied");

    chk_region_pri: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        accept && hit0 |=> CACHEABLE_O == !$past(region0_ff[REG_POLICY_BIT]))
        else $error("region zero did not take precedence");
endmodule

// ### verif/ext_bus_model.sv
// far-side bus controller: finishes unposted external writes after a set delay
// assumes the block drops REF_READY_O while it waits for the external cycle
`timescale 1ns/1ps
module ext_bus_model (
    // clock and block state
    input wire logic clk_i,
    input wire logic attr_valid_i,
    input wire logic ref_ready_i,
    input wire logic [1:0] delay_i,
    // completion strobe
    output logic done_o
);
    int cnt = 0;
    logic busy = 1'b0;
    // count down from the first waiting cycle, then pulse done for one cycle;
    // the strobe is low outside that pulse, so a stale done never looks fresh
    always @(negedge clk_i) begin
        if (attr_valid_i && !ref_ready_i) begin
            busy = 1'b1;
            cnt = delay_i;
        end
        // one assignment per edge, so the strobe never glitches within a step
        done_o <= busy && (cnt == 0);
        if (busy) begin
            if (cnt == 0) begin
                busy = 1'b0;
            end else begin
                cnt = cnt - 1;
            end
        end
    end
    initial done_o = 1'b0;
endmodule

// ### verif/memory_attribute_select_bench.sv
// self-checking bench: register moves, fill size table, writes, random references
// assumes ext_bus_model stands in for the bus controller finishing external writes
`timescale 1ns/1ps
module memory_attribute_select_bench;
    import mattr_pkg::*;
    logic clk = 1'b0;
    logic rstn, cr_wr, cr_rd, dbg, s_valid, r_valid, r_wr, r_if, r_sup, done;
    logic [11:0] cr_code;
    logic [31:0] cr_wdata, cr_rdata, r_addr, sh_cc, sh_r0, sh_r1, seed, rnd;
    logic [31:13] s_base;
    logic [1:0] delay;
    logic ready, a_valid, cach, post, ssel, fline, fbuf, alloc, term, err;
    int n_mismatch, comparisons, cycles;

    // 250 MHz system clock
    always #2 clk = ~clk;

    memory_attribute_select dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .CREG_WR_I(cr_wr),
        .CREG_RD_I(cr_rd), .CREG_CODE_I(cr_code), .CREG_WDATA_I(cr_wdata),
        .DBG_HALT_I(dbg), .CREG_RDATA_O(cr_rdata), .SRAM_BASE_I(s_base),
        .SRAM_VALID_I(s_valid), .REF_VALID_I(r_valid), .REF_ADDR_I(r_addr),
        .REF_WRITE_I(r_wr), .REF_IFETCH_I(r_if), .REF_SUPER_I(r_sup), .REF_READY_O(ready),
        .ATTR_VALID_O(a_valid), .CACHEABLE_O(cach), .POSTED_O(post), .SRAM_SEL_O(ssel),
        .FILL_LINE_O(fline), .FILL_BUF_O(fbuf), .ALLOC_O(alloc), .EXT_WR_DONE_I(done),
        .LB_WR_TERM_O(term), .LB_WR_ERR_O(err));

    ext_bus_model far (.clk_i(clk), .attr_valid_i(a_valid), .ref_ready_i(ready),
        .delay_i(delay), .done_o(done));

    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // bench model of one region compare
    function automatic logic hit(input logic [31:0] r, input logic [31:0] a, input logic s);
        return r[ACTIVE_BIT] && (((r[31:24] ^ a[31:24]) & ~r[23:16]) == 8'h00)
            && (r[PRIV_HI] || (r[PRIV_LO] == s));
    endfunction

    // high when the selector asks for a whole line at this longword offset
    function automatic logic line_exp(input logic [1:0] sel, input logic [1:0] ofs);
        return sel[1] || (sel[0] ? !ofs[1] : ofs != 2'b11);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one control register move in, shadow kept with reserved bits dropped
    task automatic creg_wr(input logic [11:0] c, input logic [31:0] d);
        @(negedge clk);
        cr_wr = 1'b1;
        cr_code = c;
        cr_wdata = d;
        @(negedge clk);
        cr_wr = 1'b0;
        if (c == CODE_CACHE_CTRL) sh_cc = d & CACHE_CTRL_WMASK;
        if (c == CODE_REGION_ZERO) sh_r0 = d & REGION_WMASK;
        if (c == CODE_REGION_ONE) sh_r1 = d & REGION_WMASK;
    endtask

    task automatic creg_rd(input logic [11:0] c);
        logic [31:0] e;
        e = (c == CODE_CACHE_CTRL) ? sh_cc : (c == CODE_REGION_ZERO) ? sh_r0 :
            (c == CODE_REGION_ONE) ? sh_r1 : 32'h0000_0000;
        @(negedge clk);
        cr_rd = 1'b1;
        cr_code = c;
        @(negedge clk);
        cr_rd = 1'b0;
        check("read data", cr_rdata, dbg ? e : 32'h0000_0000);
        @(negedge clk);
        check("read data idle", cr_rdata, 32'h0000_0000);
    endtask

    // one reference: held until taken, answer checked the cycle after the take
    task automatic ref_do(input logic [31:0] a, input logic w, input logic f, input logic s);
        logic sr, h0, h1, pol, pst, grd, fetch, now, lx;
        int n;
        sr = s_valid && (a[31:13] == s_base);
        h0 = hit(sh_r0, a, s);
        h1 = hit(sh_r1, a, s);
        pol = h0 ? sh_r0[REG_POLICY_BIT] : h1 ? sh_r1[REG_POLICY_BIT] : sh_cc[DEF_POLICY_BIT];
        pst = h0 ? sh_r0[REG_POSTED_BIT] : h1 ? sh_r1[REG_POSTED_BIT] : sh_cc[DEF_POSTED_BIT];
        grd = h0 ? sh_r0[REG_GUARD_BIT] : h1 ? sh_r1[REG_GUARD_BIT] : sh_cc[DEF_GUARD_BIT];
        fetch = f && !w && sh_cc[ICACHE_ON_BIT] && !sr;
        now = sr || grd || pst;
        lx = (!pol || sh_cc[BURST_ALLOW_BIT]) && line_exp(sh_cc[1:0], a[3:2]);
        @(negedge clk);
        r_valid = 1'b1;
        r_addr = a;
        r_wr = w;
        r_if = f;
        r_sup = s;
        n = 0;
        while (ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        r_valid = 1'b0;
        check("attr valid", a_valid, 1'b1);
        check("sram select", ssel, sr);
        check("cacheable", cach, !sr && !pol);
        check("allocate", alloc, fetch && !pol);
        check("fill buffer", fbuf, fetch && (!pol || sh_cc[BURST_ALLOW_BIT]));
        check("fill line", fline, fetch && lx);
        if (w && !sr && !grd) check("posted", post, pst);
        check("write term", term, w && now);
        check("write error", err, w && grd && !sr);
        check("ready", ready, !(w && !now));
        if (w && !now) begin
            n = 0;
            while (term !== 1'b1 && n < 10) begin
                @(negedge clk);
                n++;
            end
            check("unposted wait", n, delay + 1);
            check("unposted error", err, 1'b0);
            check("ready after done", ready, 1'b1);
        end
    endtask

    // main sequence
    initial begin
        {rstn, cr_wr, cr_rd, dbg, s_valid, r_valid, r_wr, r_if, r_sup} = 9'h000;
        cr_code = 12'h000;
        cr_wdata = 32'h0000_0000;
        r_addr = 32'h0000_0000;
        s_base = 19'h00000;
        delay = 2'h0;
        {sh_cc, sh_r0, sh_r1} = 96'h0;
        seed = 32'h4e7091a6;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        // reset values, debug-only readback, reserved bits, an unknown code
        dbg = 1'b1;
        creg_rd(CODE_CACHE_CTRL);
        creg_rd(CODE_REGION_ZERO);
        creg_rd(CODE_REGION_ONE);
        creg_wr(CODE_REGION_ONE, 32'hffff_ffff);
        creg_wr(12'h003, 32'hffff_ffff);
        creg_rd(CODE_REGION_ONE);
        creg_rd(12'h003);
        dbg = 1'b0;
        creg_rd(CODE_REGION_ONE);
        creg_wr(CODE_REGION_ONE, 32'h0000_0000);
        $display("test registers done");
        // every selector and offset for cacheable, bursting and plain uncached fetches
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 16; k++) begin
                creg_wr(CODE_CACHE_CTRL, {1'b1, 20'h00000, m == 1, m > 0, 7'h00, k[3:2]});
                ref_do({24'h000100, 4'h0, k[1:0], 2'b00}, 1'b0, 1'b1, 1'b1);
            end
        end
        $display("test fill size done");
        // guarded default write, slow unposted write, posted write
        delay = 2'h3;
        creg_wr(CODE_CACHE_CTRL, 32'h0000_0020);
        ref_do(32'h0100_0000, 1'b1, 1'b0, 1'b0);
        creg_wr(CODE_CACHE_CTRL, 32'h0000_0000);
        ref_do(32'h0100_0000, 1'b1, 1'b0, 1'b0);
        creg_wr(CODE_CACHE_CTRL, 32'h0000_0100);
        ref_do(32'h0100_0000, 1'b1, 1'b0, 1'b0);
        $display("test writes done");
        // a reset in mid-run must wipe region zero, which was written just before it
        creg_wr(CODE_REGION_ZERO, 32'hffff_ffff);
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        {sh_cc, sh_r0, sh_r1} = 96'h0;
        dbg = 1'b1;
        creg_rd(CODE_REGION_ZERO);
        creg_rd(CODE_CACHE_CTRL);
        $display("test mid-run reset done");
        // random registers, sram placement and references; narrow tops make hits common
        for (int i = 0; i < 600; i++) begin
            if (i % 8 == 0) begin
                creg_wr(CODE_CACHE_CTRL, xs());
                creg_wr(CODE_REGION_ZERO, xs() & 32'h03ff_ffff);
                creg_wr(CODE_REGION_ONE, xs() & 32'h03ff_ffff);
                rnd = xs();
                @(negedge clk);
                s_base = {6'h00, rnd[12:0]};
                s_valid = rnd[20];
                dbg = rnd[21];
                creg_rd(rnd[22] ? CODE_REGION_ZERO : CODE_CACHE_CTRL);
            end
            rnd = xs();
            delay = rnd[27:26];
            ref_do(rnd[30] ? {s_base, rnd[12:0]} : rnd & 32'h03ff_ffff,
                rnd[31], rnd[29] && !rnd[31], rnd[28]);
        end
        $display("test random references done");
        tally_and_finish();
    end
endmodule
